// *** tc2_pkg.sv ***
// constants shared by the timer control and compare block
// assumes an 8-bit i/o register bus with byte offsets
`default_nettype none
package tc2_pkg;
   // ----------------------------------------
   // register offsets
   // ----------------------------------------
   localparam logic [7:0] OFS_FLAGS = 8'h37;
   localparam logic [7:0] OFS_MASK  = 8'h70;
   localparam logic [7:0] OFS_CTRLB = 8'hb1;
   localparam logic [7:0] OFS_COUNT = 8'hb2;
   localparam logic [7:0] OFS_CMPA  = 8'hb3;
   localparam logic [7:0] OFS_CMPB  = 8'hb4;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int BIT_FORCE_A = 7;
   localparam int BIT_FORCE_B = 6;
   localparam int BIT_WGM2    = 3;
   localparam int BIT_CMPB    = 2;
   localparam int BIT_CMPA    = 1;
   localparam int BIT_OVF     = 0;
   // ----------------------------------------
   // reset values and fixed levels
   // ----------------------------------------
   localparam logic [7:0] RST_REG   = 8'h00;
   localparam logic [7:0] COUNT_MAX = 8'hff;
   localparam logic [7:0] COUNT_BOT = 8'h00;
   localparam int         PRE_W     = 10;
   localparam logic [PRE_W-1:0] RST_PRE = 10'h000;
   // ----------------------------------------
   // prescaler masks, tick when all masked bits set
   // ----------------------------------------
   localparam logic [PRE_W-1:0] MASK_1    = 10'h000;
   localparam logic [PRE_W-1:0] MASK_8    = 10'h007;
   localparam logic [PRE_W-1:0] MASK_32   = 10'h01f;
   localparam logic [PRE_W-1:0] MASK_64   = 10'h03f;
   localparam logic [PRE_W-1:0] MASK_128  = 10'h07f;
   localparam logic [PRE_W-1:0] MASK_256  = 10'h0ff;
   localparam logic [PRE_W-1:0] MASK_1024 = 10'h3ff;
   // ----------------------------------------
   // output modes
   // ----------------------------------------
   localparam logic [1:0] OM_OFF = 2'h0;
   localparam logic [1:0] OM_TGL = 2'h1;
   localparam logic [1:0] OM_CLR = 2'h2;
   localparam logic [1:0] OM_SET = 2'h3;
   typedef enum logic [1:0] {
      SEQ_NORMAL,
      SEQ_CTC,
      SEQ_FAST,
      SEQ_PHASE
   } tc2_seq_t;
endpackage : tc2_pkg
`default_nettype wire

// *** tc2_timer.sv ***
// 8-bit timer: control b, count, two compares, irq mask, flags
// assumes synchronous single-cycle i/o writes and reads on clk
`default_nettype none
// Function
// - force strobe in non-pwm mode applies compare action to wave output
// - forced compare sets no flag, requests nothing, never clears counter
// - force strobe bits always read back as zero
// - clock select picks stop, undivided, or divide 8 to 1024
// - count register read/write; write blocks match on next timer tick
// - both compare registers match count continuously, drive flag and wave
// - compare b irq when its enable, global enable and flag set
// - compare a irq when its enable, global enable and flag set
// - overflow irq when its enable, global enable and flag set
// - mode bit2 with low bits picks sequence, top and wave; 4,6 reserved
// - flags cleared by vector acknowledge or writing one
module tc2_timer (
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic [7:0] ioAddr,
   input  wire logic [7:0] ioWrData,
   input  wire logic       ioWrEn,
   input  wire logic       ioRdEn,
   output logic      [7:0] ioRdData,
   input  wire logic [1:0] waveModeLow,
   input  wire logic [1:0] outModeA,
   input  wire logic [1:0] outModeB,
   input  wire logic       globalIrqEnable,
   input  wire logic       ackCompA,
   input  wire logic       ackCompB,
   input  wire logic       ackOverflow,
   output logic            irqCompA,
   output logic            irqCompB,
   output logic            irqOverflow,
   output logic            waveOutA,
   output logic            waveOutB
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [7:0]  countQ_q, cmpA_q, cmpB_q;
   logic [2:0]  clockSelect_q, irqMask_q, flags_q;
   logic        waveModeBit2_q, countDown_q, blockMatch_q;
   logic        waveA_q, waveB_q;
   logic [tc2_pkg::PRE_W-1:0] pre_q;
   logic [7:0]  count_d, rdData_d;
   logic        down_d;
   logic [2:0]  flags_d;

   // ----------------------------------------
   // decode
   // ----------------------------------------
   function automatic logic [tc2_pkg::PRE_W-1:0] preMask(input logic [2:0] cs);
      case (cs)
         3'h1:    preMask = tc2_pkg::MASK_1;
         3'h2:    preMask = tc2_pkg::MASK_8;
         3'h3:    preMask = tc2_pkg::MASK_32;
         3'h4:    preMask = tc2_pkg::MASK_64;
         3'h5:    preMask = tc2_pkg::MASK_128;
         3'h6:    preMask = tc2_pkg::MASK_256;
         default: preMask = tc2_pkg::MASK_1024;
      endcase
   endfunction : preMask

   // next wave level for one channel; also serves the forced strobe
   function automatic logic waveNext(
      input logic cur, input logic [1:0] om, input tc2_pkg::tc2_seq_t seq,
      input logic match, input logic bottom, input logic down, input logic tglOk);
      logic v;
      v = cur;
      case (seq)
         tc2_pkg::SEQ_FAST: begin
            if (match && om == tc2_pkg::OM_TGL && tglOk) v = ~cur;
            else if (match && om == tc2_pkg::OM_CLR) v = 1'b0;
            else if (match && om == tc2_pkg::OM_SET) v = 1'b1;
            else if (bottom && om == tc2_pkg::OM_CLR) v = 1'b1;
            else if (bottom && om == tc2_pkg::OM_SET) v = 1'b0;
         end
         tc2_pkg::SEQ_PHASE: begin
            if (match && om == tc2_pkg::OM_TGL && tglOk) v = ~cur;
            else if (match && om == tc2_pkg::OM_CLR) v = down;
            else if (match && om == tc2_pkg::OM_SET) v = ~down;
         end
         default: begin
            if (match && om == tc2_pkg::OM_TGL) v = ~cur;
            else if (match && om == tc2_pkg::OM_CLR) v = 1'b0;
            else if (match && om == tc2_pkg::OM_SET) v = 1'b1;
         end
      endcase
      waveNext = v;
   endfunction : waveNext

   wire [2:0] waveMode = {waveModeBit2_q, waveModeLow};
   tc2_pkg::tc2_seq_t seq;
   // reserved codes 4 and 6 count as normal, top at max
   always_comb begin
      case (waveMode)
         3'h1, 3'h5: seq = tc2_pkg::SEQ_PHASE;
         3'h2:       seq = tc2_pkg::SEQ_CTC;
         3'h3, 3'h7: seq = tc2_pkg::SEQ_FAST;
         default:    seq = tc2_pkg::SEQ_NORMAL;
      endcase
   end
   wire topIsCmpA = (waveMode == 3'h2) || waveMode[2] && waveMode[0];
   wire [7:0] topVal = topIsCmpA ? cmpA_q : tc2_pkg::COUNT_MAX;
   wire isPwm = (seq == tc2_pkg::SEQ_FAST) || (seq == tc2_pkg::SEQ_PHASE);

   wire selFlags = ioAddr == tc2_pkg::OFS_FLAGS;
   wire selMask  = ioAddr == tc2_pkg::OFS_MASK;
   wire selCtrlB = ioAddr == tc2_pkg::OFS_CTRLB;
   wire selCount = ioAddr == tc2_pkg::OFS_COUNT;
   wire selCmpA  = ioAddr == tc2_pkg::OFS_CMPA;
   wire selCmpB  = ioAddr == tc2_pkg::OFS_CMPB;
   wire wrCount  = ioWrEn && selCount;
   wire wrCtrlB  = ioWrEn && selCtrlB;

   // ----------------------------------------
   // prescaler and timer tick
   // ----------------------------------------
   wire [tc2_pkg::PRE_W-1:0] mask = preMask(clockSelect_q);
   wire tick = (clockSelect_q != 3'h0) && ((pre_q & mask) == mask);

   // ----------------------------------------
   // compare and counting
   // ----------------------------------------
   wire atTop   = countQ_q == topVal;
   wire atBot   = countQ_q == tc2_pkg::COUNT_BOT;
   wire matchA  = tick && !blockMatch_q && (countQ_q == cmpA_q);
   wire matchB  = tick && !blockMatch_q && (countQ_q == cmpB_q);
   wire turnBot = tick && seq == tc2_pkg::SEQ_PHASE && countDown_q && atBot;
   wire ovfMax  = (waveMode == 3'h7) ? atTop : (countQ_q == tc2_pkg::COUNT_MAX);
   wire ovfEv   = (seq == tc2_pkg::SEQ_PHASE) ? turnBot : (tick && ovfMax);
   wire forceA  = wrCtrlB && ioWrData[tc2_pkg::BIT_FORCE_A] && !isPwm;
   wire forceB  = wrCtrlB && ioWrData[tc2_pkg::BIT_FORCE_B] && !isPwm;

   always_comb begin
      count_d = countQ_q;
      down_d  = countDown_q;
      if (wrCount) begin
         count_d = ioWrData;
      end else if (tick && seq == tc2_pkg::SEQ_PHASE) begin
         if (countDown_q && atBot) begin
            down_d  = 1'b0;
            count_d = 8'(countQ_q + 8'h01);
         end else if (!countDown_q && atTop) begin
            down_d  = 1'b1;
            count_d = 8'(countQ_q - 8'h01);
         end else begin
            count_d = countDown_q ? 8'(countQ_q - 8'h01) : 8'(countQ_q + 8'h01);
         end
      end else if (tick) begin
         // ctc clear comes from top only, so a forced strobe cannot clear
         count_d = atTop ? tc2_pkg::COUNT_BOT : 8'(countQ_q + 8'h01);
      end
   end

   // set wins over both clears
   always_comb begin
      flags_d = flags_q;
      if (ioWrEn && selFlags) flags_d = flags_d & ~ioWrData[2:0];
      if (ackCompB)    flags_d[tc2_pkg::BIT_CMPB] = 1'b0;
      if (ackCompA)    flags_d[tc2_pkg::BIT_CMPA] = 1'b0;
      if (ackOverflow) flags_d[tc2_pkg::BIT_OVF]  = 1'b0;
      if (matchB) flags_d[tc2_pkg::BIT_CMPB] = 1'b1;
      if (matchA) flags_d[tc2_pkg::BIT_CMPA] = 1'b1;
      if (ovfEv)  flags_d[tc2_pkg::BIT_OVF]  = 1'b1;
   end

   // ----------------------------------------
   // read mux
   // ----------------------------------------
   always_comb begin
      rdData_d = 8'h00;
      if (selFlags) rdData_d = {5'h00, flags_q};
      if (selMask)  rdData_d = {5'h00, irqMask_q};
      if (selCtrlB) rdData_d = {4'h0, waveModeBit2_q, clockSelect_q};
      if (selCount) rdData_d = countQ_q;
      if (selCmpA)  rdData_d = cmpA_q;
      if (selCmpB)  rdData_d = cmpB_q;
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pre_q          <= tc2_pkg::RST_PRE;
         countQ_q       <= tc2_pkg::RST_REG;
         countDown_q    <= 1'b0;
         blockMatch_q   <= 1'b0;
         flags_q        <= 3'h0;
         ioRdData       <= tc2_pkg::RST_REG;
      end else begin
         pre_q          <= tc2_pkg::PRE_W'(pre_q + 1'b1);
         countQ_q       <= count_d;
         countDown_q    <= down_d;
         // held until the next timer tick has passed
         blockMatch_q   <= wrCount | (blockMatch_q & ~tick);
         flags_q        <= flags_d;
         if (ioRdEn) ioRdData <= rdData_d;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         clockSelect_q  <= 3'h0;
         waveModeBit2_q <= 1'b0;
         irqMask_q      <= 3'h0;
         cmpA_q         <= tc2_pkg::RST_REG;
         cmpB_q         <= tc2_pkg::RST_REG;
      end else begin
         if (wrCtrlB) begin
            clockSelect_q  <= ioWrData[2:0];
            waveModeBit2_q <= ioWrData[tc2_pkg::BIT_WGM2];
         end
         if (ioWrEn && selMask) irqMask_q <= ioWrData[2:0];
         if (ioWrEn && selCmpA) cmpA_q <= ioWrData;
         if (ioWrEn && selCmpB) cmpB_q <= ioWrData;
      end
   end

   // ----------------------------------------
   // wave outputs
   // ----------------------------------------
   wire bottomEv = tick && seq == tc2_pkg::SEQ_FAST && atTop;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         waveA_q <= 1'b0;
         waveB_q <= 1'b0;
      end else begin
         waveA_q <= waveNext(waveA_q, outModeA, seq, matchA | forceA, bottomEv,
                             countDown_q, waveModeBit2_q);
         waveB_q <= waveNext(waveB_q, outModeB, seq, matchB | forceB, bottomEv,
                             countDown_q, 1'b0);
      end
   end
   assign waveOutA = waveA_q;
   assign waveOutB = waveB_q;

   // ----------------------------------------
   // interrupt requests
   // ----------------------------------------
   assign irqCompB    = irqMask_q[tc2_pkg::BIT_CMPB] & globalIrqEnable
                      & flags_q[tc2_pkg::BIT_CMPB];
   assign irqCompA    = irqMask_q[tc2_pkg::BIT_CMPA] & globalIrqEnable
                      & flags_q[tc2_pkg::BIT_CMPA];
   assign irqOverflow = irqMask_q[tc2_pkg::BIT_OVF] & globalIrqEnable
                      & flags_q[tc2_pkg::BIT_OVF];

   // ----------------------------------------
   // checks
   // ----------------------------------------
   // count write seen and no timer tick since; kept apart from the blocking flag
   logic wrPend_q;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wrPend_q <= 1'b0;
      end else if (wrCount) begin
         wrPend_q <= 1'b1;
      end else if (tick) begin
         wrPend_q <= 1'b0;
      end
   end

   a_force_no_flag: assert property (forceA && !matchA && !ackCompA
      |=> flags_q[1] == $past(flags_q[1])) else $error("force set flag");
   a_force_no_clear: assert property (forceA && !tick && !wrCount
      |=> countQ_q == $past(countQ_q)) else $error("force moved count");
   a_force_wave: assert property (forceB && outModeB == tc2_pkg::OM_SET
      |=> waveOutB) else $error("force b no effect");
   a_ctrl_read: assert property (ioRdEn && selCtrlB
      |=> ioRdData[7:6] == 2'h0 && ioRdData[5:4] == 2'h0) else $error("ctrl b read");
   a_stop_hold: assert property (clockSelect_q == 3'h0 && !wrCount
      |=> countQ_q == $past(countQ_q)) else $error("stopped count moved");
   a_div8_tick: assert property (clockSelect_q == 3'h2 && tick
      |=> (!tick || clockSelect_q != 3'h2) [*7]) else $error("div 8 spacing");
   a_block_match: assert property (wrPend_q && tick
      |-> !matchA && !matchB) else $error("match not blocked");
   a_match_flag: assert property (matchA |=> flags_q[1]) else $error("a flag lost");
   a_irq_b: assert property (
      irqCompB == (irqMask_q[2] && globalIrqEnable && flags_q[2])) else $error("irq b");
   a_irq_a: assert property ($rose(irqCompA)
      |-> $past(matchA) || $past(ioWrEn && selMask) || $rose(globalIrqEnable))
      else $error("irq a");
   a_irq_ovf: assert property ($rose(irqOverflow)
      |-> $past(ovfEv) || $past(wrCtrlB) || $past(ioWrEn && selMask)
      || $rose(globalIrqEnable)) else $error("irq ovf");
   a_ack_clear: assert property (ackOverflow && !ovfEv |=> !flags_q[0])
      else $error("ovf ack");
   a_mask_read: assert property (ioRdEn && selMask |=> ioRdData[7:3] == 5'h00)
      else $error("mask read");

   c_match_a:    cover property (matchA && irqMask_q[1]);
   c_overflow:   cover property (ovfEv && seq == tc2_pkg::SEQ_NORMAL);
   c_phase_turn: cover property (turnBot);
   c_force_a:    cover property (forceA);
   c_blocked:    cover property (wrPend_q && tick && countQ_q == cmpA_q);
endmodule : tc2_timer
`default_nettype wire

// *** tc2_cpu_model.sv ***
// processor-side model driving the timer's i/o register bus
// assumes single-cycle write and read strobes sampled on rising clk
`default_nettype none
module tc2_cpu_model (
   input  wire logic       clk,
   input  wire logic [1:0] waveModeLow,
   input  wire logic [7:0] ioRdData,
   output logic      [7:0] ioAddr,
   output logic      [7:0] ioWrData,
   output logic            ioWrEn,
   output logic            ioRdEn
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      ioAddr   = 8'h00;
      ioWrData = 8'h00;
      ioWrEn   = 1'b0;
      ioRdEn   = 1'b0;
   end
   // released lines show the inverse, so stale data never matches
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] v;
      v = d;
      if (a === tc2_pkg::OFS_CTRLB && waveModeLow[0]) v[7:6] = 2'b00;
      @(negedge clk);
      ioAddr   = a;
      ioWrData = v;
      ioWrEn   = 1'b1;
      @(negedge clk);
      ioWrEn   = 1'b0;
      ioWrData = ~v;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      ioAddr = a;
      ioRdEn = 1'b1;
      @(negedge clk);
      ioRdEn = 1'b0;
      ioAddr = ~a;
      @(negedge clk);
      d = ioRdData;
   endtask : rd
endmodule : tc2_cpu_model
`default_nettype wire

// *** tc2_tb.sv ***
// self-checking bench for the timer control and compare block
// assumes the cpu model owns the register bus; bench owns side inputs
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk, resetn, gIe, ackA, ackB, ackO, irqA, irqB, irqO, wA, wB;
   logic [1:0] wml, omA, omB;
   logic [7:0] ioAddr, ioWrData, ioRdData, v, rv;
   logic       ioWrEn, ioRdEn, expA, expB;
   int         miscompares, nTests, seed, i, c, m;
   int         dv[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
   int         expReg[int];
   tc2_cpu_model tc2_cpu_model_inst (.clk(clk), .waveModeLow(wml), .ioRdData(ioRdData),
      .ioAddr(ioAddr), .ioWrData(ioWrData), .ioWrEn(ioWrEn), .ioRdEn(ioRdEn));
   tc2_timer tc2_timer_inst (.clk(clk), .resetn(resetn), .ioAddr(ioAddr),
      .ioWrData(ioWrData), .ioWrEn(ioWrEn), .ioRdEn(ioRdEn), .ioRdData(ioRdData),
      .waveModeLow(wml), .outModeA(omA), .outModeB(omB), .globalIrqEnable(gIe),
      .ackCompA(ackA), .ackCompB(ackB), .ackOverflow(ackO), .irqCompA(irqA),
      .irqCompB(irqB), .irqOverflow(irqO), .waveOutA(wA), .waveOutB(wB));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      nTests++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic w(input logic [7:0] a, input logic [7:0] d);
      tc2_cpu_model_inst.wr(a, d);
   endtask : w
   task automatic pulse(input int k);
      @(negedge clk);
      {ackB, ackA, ackO} = 3'(k);
      @(negedge clk);
      {ackB, ackA, ackO} = 3'b000;
      @(negedge clk);
   endtask : pulse
   task automatic tallyAndFinish();
      $display("compares %0d mismatches %0d", nTests, miscompares);
      if (miscompares == 0 && nTests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : tallyAndFinish
   initial begin
      repeat (60000) @(posedge clk);
      miscompares++;
      tallyAndFinish();
   end
   initial begin
      {resetn, gIe, ackA, ackB, ackO, wml, omA, omB} = '0;
      {miscompares, nTests} = '0;
      seed = 79;
      repeat (8) @(negedge clk);
      resetn = 1'b1;
      // ---------------- reset values, unmapped address ----------------
      foreach (dv[k]) begin
         tc2_cpu_model_inst.rd(8'(8'hb0 + k), v);
         chk(v, 8'h00);
      end
      tc2_cpu_model_inst.rd(tc2_pkg::OFS_MASK, v);
      chk(v, 8'h00);
      // ---------------- random readback -------------------------------
      expReg[tc2_pkg::OFS_MASK] = 8'h07;
      expReg[tc2_pkg::OFS_CTRLB] = 8'h08;
      expReg[tc2_pkg::OFS_COUNT] = 8'hff;
      expReg[tc2_pkg::OFS_CMPA] = 8'hff;
      expReg[tc2_pkg::OFS_CMPB] = 8'hff;
      for (i = 0; i < 4; i++) foreach (expReg[a]) begin
         v = 8'($random(seed));
         if (a == tc2_pkg::OFS_CTRLB) v = v & 8'h38;
         w(8'(a), v);
         v = v & 8'(expReg[a]);
         tc2_cpu_model_inst.rd(8'(a), rv);
         chk(rv, v);
      end
      // ---------------- clock select codes ----------------------------
      for (c = 0; c < 8; c++) begin
         w(tc2_pkg::OFS_COUNT, 8'h00);
         w(tc2_pkg::OFS_CTRLB, 8'(c));
         repeat (c == 0 ? 16 : 8 * dv[c]) @(negedge clk);
         w(tc2_pkg::OFS_CTRLB, 8'h00);
         tc2_cpu_model_inst.rd(tc2_pkg::OFS_COUNT, v);
         if (c == 0) chk(v, 8'h00);
         else chk(8'(v >= 8'd7 && v <= 8'd11), 8'h01);
      end
      // ---------------- all modes, forced compare only in modes 0,2,4,6 ----
      w(tc2_pkg::OFS_FLAGS, 8'h07);
      w(tc2_pkg::OFS_MASK, 8'h07);
      w(tc2_pkg::OFS_CMPA, 8'h80);
      w(tc2_pkg::OFS_CMPB, 8'h90);
      w(tc2_pkg::OFS_COUNT, 8'h33);
      {gIe, omA, expA, expB} = {1'b1, tc2_pkg::OM_TGL, 2'b00};
      for (m = 0; m < 8; m++) begin
         wml = 2'(m);
         omB = m[1] ? tc2_pkg::OM_SET : tc2_pkg::OM_CLR;
         w(tc2_pkg::OFS_CTRLB, {2'b11, 2'b00, 1'(m >> 2), 3'b000});
         if (!m[0]) {expA, expB} = {~expA, m[1]};
         tc2_cpu_model_inst.rd(tc2_pkg::OFS_CTRLB, v);
         chk(v, m[2] ? 8'h08 : 8'h00);
         chk({wB, wA, irqB, irqA}, {expB, expA, 2'b00});
      end
      tc2_cpu_model_inst.rd(tc2_pkg::OFS_COUNT, v);
      chk(v, 8'h33);
      // ---------------- matches, overflow, mask and clearing ----------
      wml = 2'b00;
      w(tc2_pkg::OFS_CMPA, 8'h20);
      w(tc2_pkg::OFS_CMPB, 8'h40);
      w(tc2_pkg::OFS_COUNT, 8'h10);
      w(tc2_pkg::OFS_CTRLB, 8'h01);
      for (i = 0; i < 400 && irqO !== 1'b1; i++) @(negedge clk);
      w(tc2_pkg::OFS_CTRLB, 8'h00);
      for (m = 0; m < 16; m++) begin
         w(tc2_pkg::OFS_MASK, 8'(m & 7));
         gIe = 1'(m >> 3);
         @(negedge clk);
         chk({irqB, irqA, irqO}, 8'((m & 7) * (m >> 3)));
      end
      pulse(2);
      chk({irqB, irqA, irqO}, 8'h05);
      w(tc2_pkg::OFS_FLAGS, 8'h04);
      chk({irqB, irqA, irqO}, 8'h01);
      pulse(1);
      chk({irqB, irqA, irqO}, 8'h00);
      // ---------------- count write blocks next match -----------------
      w(tc2_pkg::OFS_CMPA, 8'h50);
      w(tc2_pkg::OFS_COUNT, 8'h4e);
      w(tc2_pkg::OFS_CTRLB, 8'h01);
      repeat (10) @(negedge clk);
      chk(irqA, 1'b1);
      w(tc2_pkg::OFS_FLAGS, 8'h07);
      w(tc2_pkg::OFS_COUNT, 8'h50);
      repeat (10) @(negedge clk);
      w(tc2_pkg::OFS_CTRLB, 8'h00);
      chk(irqA, 1'b0);
      // ---------------- phase correct: overflow only on turn at bottom -
      w(tc2_pkg::OFS_FLAGS, 8'h07);
      w(tc2_pkg::OFS_MASK, 8'h01);
      wml = 2'b01;
      w(tc2_pkg::OFS_COUNT, 8'hf0);
      w(tc2_pkg::OFS_CTRLB, 8'h01);
      for (i = 0; i < 400 && irqO !== 1'b1; i++) @(negedge clk);
      w(tc2_pkg::OFS_CTRLB, 8'h00);
      // 15 ticks up to max, 255 down to zero, turn on the next tick
      chk(8'(i >= 265 && i <= 275), 8'h01);
      tallyAndFinish();
   end
endmodule : tb
`default_nettype wire
